// ==== shared/cvo_pkg.sv ====
// channel gain and output stage configuration: offsets, reset values, fields, types
// assumes one control clock domain shared with the control port that drives it
package cvo_pkg;

  // ********************************************************************
  // register offsets on the control port
  // ********************************************************************
  localparam logic [7:0] CVO_OFF_LEFT_GAIN  = 8'h04;
  localparam logic [7:0] CVO_OFF_RIGHT_GAIN = 8'h05;
  localparam logic [7:0] CVO_OFF_STAGE_CFG  = 8'h06;
  localparam logic [7:0] CVO_OFF_RESERVED   = 8'h07;

  // ********************************************************************
  // reset values and gain code landmarks
  // ********************************************************************
  localparam logic [7:0] CVO_GAIN_RESET     = 8'hcf;
  localparam logic [7:0] CVO_GAIN_UNITY     = 8'hcf;
  localparam logic [7:0] CVO_GAIN_MAX       = 8'hff;
  localparam logic [7:0] CVO_GAIN_FLOOR     = 8'h07;
  localparam logic [7:0] CVO_STAGE_RESET    = 8'h51;
  localparam logic [7:0] CVO_READ_ZERO      = 8'h00;

  // ********************************************************************
  // output stage configuration field positions
  // ********************************************************************
  localparam int CVO_BIT_PAR_BRIDGE = 7;
  localparam int CVO_BIT_RATE_HI    = 6;
  localparam int CVO_BIT_RATE_LO    = 4;
  localparam int CVO_BIT_AGAIN_HI   = 3;
  localparam int CVO_BIT_AGAIN_LO   = 2;
  localparam int CVO_BIT_MONO_SRC   = 1;
  localparam int CVO_BIT_KEEP_ONE   = 0;

  localparam logic [2:0] CVO_RATE_RESET  = 3'h5;
  localparam logic [4:0] CVO_MULT_RESET  = 5'h10;
  localparam logic [1:0] CVO_AGAIN_RESET = 2'h0;
  localparam logic [1:0] CVO_AGAIN_RSVD  = 2'h3;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {
    CVO_AGAIN_LOW,
    CVO_AGAIN_MID,
    CVO_AGAIN_HIGH,
    CVO_AGAIN_RESERVED
  } cvo_again_t;

  // field layout of the output stage configuration register
  typedef struct packed {
    logic       parallel_bridge_enable;
    logic [2:0] rate_code;
    logic [1:0] analog_gain_sel;
    logic       mono_source_sel;
    logic       keep_one;
  } cvo_stage_t;

  // one host access on the control port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cvo_req_t;

  // decoded gain of one channel, in half decibel steps
  typedef struct packed {
    logic              mute;
    logic signed [8:0] half_db;
  } cvo_chan_t;

  // decoded output stage settings
  typedef struct packed {
    logic       parallel_bridge_enable;
    logic       mono_source_sel;
    logic [4:0] switch_mult;
    logic [1:0] analog_gain_sel;
  } cvo_out_t;

  // ********************************************************************
  // shared arithmetic
  // ********************************************************************
  // gain in half decibels relative to the unity code
  function automatic logic signed [8:0] cvo_half_db(input logic [7:0] code);
    cvo_half_db = $signed({1'b0, code}) - $signed({1'b0, CVO_GAIN_UNITY});
  endfunction : cvo_half_db

  // switching rate as a multiple of the frame clock
  function automatic logic [4:0] cvo_rate_mult(input logic [2:0] code);
    case (code)
      3'h0:    cvo_rate_mult = 5'h06;
      3'h1:    cvo_rate_mult = 5'h08;
      3'h2:    cvo_rate_mult = 5'h0a;
      3'h3:    cvo_rate_mult = 5'h0c;
      3'h4:    cvo_rate_mult = 5'h0e;
      3'h5:    cvo_rate_mult = 5'h10;
      3'h6:    cvo_rate_mult = 5'h14;
      default: cvo_rate_mult = 5'h18;
    endcase
  endfunction : cvo_rate_mult

endpackage : cvo_pkg

// ==== core/cvo_gain_decode.sv ====
// decodes one 8-bit channel gain code into a mute flag and a half decibel gain
// assumes the code comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module cvo_gain_decode
  import cvo_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [7:0]      code,
  output var  cvo_pkg::cvo_chan_t chan
);

  // ********************************************************************
  // decode
  // ********************************************************************
  wire logic      below_floor = (code < CVO_GAIN_FLOOR);
  wire cvo_chan_t next_chan   = '{mute: below_floor, half_db: cvo_half_db(code)};

  // registered so the amplifier sees a glitch-free setting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan <= '{mute: 1'b0, half_db: 9'sh000};
    end else begin
      chan <= next_chan;
    end
  end

endmodule : cvo_gain_decode
`default_nettype wire

// ==== core/cvo_regs.sv ====
// control port register bank: channel gain codes and output stage configuration
// assumes the control port master and the sample speed select share SYS_CLK
//
// Notes on behaviour
// - left gain register 0x04, reset 0xcf
// - right gain register 0x05, same decode
// - code 0xff gives plus 24 dB
// - each code step is 0.5 dB
// - code 0xcf is 0 dB, default
// - code 0x07 gives minus 100 dB
// - codes below 0x07 mute the channel
// - bit 7 picks bridged or parallel-bridged
// - bits 6:4 pick switching rate multiple
// - double speed halves the switching rate
// - bits 3:2 pick the analog gain
// - bit 1 picks mono source channel
// - sample speed select high means double speed
`timescale 1ns/1ps
`default_nettype none
module cvo_regs
  import cvo_pkg::*;
(
  input  wire logic               SYS_CLK,
  input  wire logic               RST_N,
  input  wire cvo_pkg::cvo_req_t  REG_REQ,
  input  wire logic               SAMPLE_SPEED_SEL,
  output var  logic [7:0]         REG_RDATA,
  output var  logic               REG_RVALID,
  output var  cvo_pkg::cvo_chan_t LEFT_GAIN,
  output var  cvo_pkg::cvo_chan_t RIGHT_GAIN,
  output var  cvo_pkg::cvo_out_t  STAGE_OUT
);

  // ********************************************************************
  // storage
  // ********************************************************************
  logic [7:0] left_gain_code;
  logic [7:0] right_gain_code;
  cvo_stage_t output_stage_config;

  // ********************************************************************
  // address decode
  // ********************************************************************
  wire logic hit_left  = (REG_REQ.addr == CVO_OFF_LEFT_GAIN);
  wire logic hit_right = (REG_REQ.addr == CVO_OFF_RIGHT_GAIN);
  wire logic hit_stage = (REG_REQ.addr == CVO_OFF_STAGE_CFG);
  wire logic wr_left   = REG_REQ.wr && hit_left;
  wire logic wr_right  = REG_REQ.wr && hit_right;
  wire logic wr_stage  = REG_REQ.wr && hit_stage;

  // the reserved slot and unmapped offsets read zero and drop writes
  wire logic [7:0] read_mux = hit_left  ? left_gain_code :
                              hit_right ? right_gain_code :
                              hit_stage ? output_stage_config :
                                          CVO_READ_ZERO;

  // ********************************************************************
  // register writes
  // ********************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      left_gain_code <= CVO_GAIN_RESET;
    end else if (wr_left) begin
      left_gain_code <= REG_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      right_gain_code <= CVO_GAIN_RESET;
    end else if (wr_right) begin
      right_gain_code <= REG_REQ.wdata;
    end
  end

  // the keep-one bit is stored as written; the host is trusted to keep it set
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      output_stage_config <= CVO_STAGE_RESET;
    end else if (wr_stage) begin
      output_stage_config <= REG_REQ.wdata;
    end
  end

  // ********************************************************************
  // read port: data one cycle after the read strobe
  // ********************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      REG_RDATA  <= CVO_READ_ZERO;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA  <= REG_REQ.rd ? read_mux : REG_RDATA;
      REG_RVALID <= REG_REQ.rd;
    end
  end

  // ********************************************************************
  // channel gain decode
  // ********************************************************************
  // one decoder per channel so both follow the identical code table
  cvo_gain_decode u_left_decode (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .code  (left_gain_code),
    .chan  (LEFT_GAIN)
  );

  cvo_gain_decode u_right_decode (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .code  (right_gain_code),
    .chan  (RIGHT_GAIN)
  );

  // ********************************************************************
  // output stage decode
  // ********************************************************************
  wire logic [4:0] base_mult = cvo_rate_mult(output_stage_config.rate_code);
  // every listed multiple is even, so the halving is exact
  wire logic [4:0] eff_mult  = SAMPLE_SPEED_SEL ? (base_mult >> 1) : base_mult;

  // a reserved analog gain code is held at the lowest setting, never passed on
  wire logic [1:0] again_eff =
    (output_stage_config.analog_gain_sel == CVO_AGAIN_RSVD) ? CVO_AGAIN_RESET :
                                                              output_stage_config.analog_gain_sel;

  wire cvo_out_t next_stage = '{
    parallel_bridge_enable: output_stage_config.parallel_bridge_enable,
    mono_source_sel:        output_stage_config.mono_source_sel,
    switch_mult:            eff_mult,
    analog_gain_sel:        again_eff
  };

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      STAGE_OUT <= '{parallel_bridge_enable: 1'b0, mono_source_sel: 1'b0,
                     switch_mult: CVO_MULT_RESET, analog_gain_sel: CVO_AGAIN_RESET};
    end else begin
      STAGE_OUT <= next_stage;
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  property p_left_write;
    @(posedge SYS_CLK) disable iff (!RST_N)
    wr_left |=> ##1 (LEFT_GAIN.half_db == cvo_half_db($past(REG_REQ.wdata, 2)));
  endproperty
  a_left_write: assert property (p_left_write)
    else $error("left gain write not reflected");

  property p_right_write;
    @(posedge SYS_CLK) disable iff (!RST_N)
    wr_right |=> (right_gain_code == $past(REG_REQ.wdata)) ##1
                 (RIGHT_GAIN.half_db == cvo_half_db($past(right_gain_code)));
  endproperty
  a_right_write: assert property (p_right_write)
    else $error("right gain write not reflected");

  property p_gain_max;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (left_gain_code == CVO_GAIN_MAX) |=> (LEFT_GAIN.half_db == 9'sd48) && !LEFT_GAIN.mute;
  endproperty
  a_gain_max: assert property (p_gain_max)
    else $error("top code is not +24 dB");

  property p_gain_step;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (left_gain_code == 8'hfe) |=> (LEFT_GAIN.half_db == 9'sd47);
  endproperty
  a_gain_step: assert property (p_gain_step)
    else $error("one step below top is not +23.5 dB");

  property p_gain_unity;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (right_gain_code == CVO_GAIN_UNITY) |=> (RIGHT_GAIN.half_db == 9'sd0) && !RIGHT_GAIN.mute;
  endproperty
  a_gain_unity: assert property (p_gain_unity)
    else $error("unity code is not 0 dB");

  property p_gain_floor;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (left_gain_code == CVO_GAIN_FLOOR) |=> (LEFT_GAIN.half_db == -9'sd200) && !LEFT_GAIN.mute;
  endproperty
  a_gain_floor: assert property (p_gain_floor)
    else $error("floor code is not -100 dB");

  property p_gain_mute;
    @(posedge SYS_CLK) disable iff (!RST_N)
    $changed(right_gain_code) |=> (RIGHT_GAIN.mute == ($past(right_gain_code) < CVO_GAIN_FLOOR));
  endproperty
  a_gain_mute: assert property (p_gain_mute)
    else $error("mute does not follow code below floor");

  property p_topology;
    @(posedge SYS_CLK) disable iff (!RST_N)
    wr_stage |=> ##1 (STAGE_OUT.parallel_bridge_enable == $past(REG_REQ.wdata[CVO_BIT_PAR_BRIDGE], 2))
                  && (STAGE_OUT.mono_source_sel == $past(REG_REQ.wdata[CVO_BIT_MONO_SRC], 2));
  endproperty
  a_topology: assert property (p_topology)
    else $error("topology or mono source not applied");

  property p_rate_default;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (output_stage_config.rate_code == CVO_RATE_RESET) && !SAMPLE_SPEED_SEL
      |=> (STAGE_OUT.switch_mult == 5'h10);
  endproperty
  a_rate_default: assert property (p_rate_default)
    else $error("rate code 101 is not 16 frames");

  property p_rate_half;
    @(posedge SYS_CLK) disable iff (!RST_N)
    SAMPLE_SPEED_SEL |=> (STAGE_OUT.switch_mult == ($past(base_mult) >> 1));
  endproperty
  a_rate_half: assert property (p_rate_half)
    else $error("double speed did not halve the rate");

  property p_analog_gain;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (output_stage_config.analog_gain_sel != CVO_AGAIN_RSVD)
      |=> (STAGE_OUT.analog_gain_sel == $past(output_stage_config.analog_gain_sel));
  endproperty
  a_analog_gain: assert property (p_analog_gain)
    else $error("analog gain selection not applied");

  property p_reserved_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
    // the reserved slot and every other unmapped offset read zero
    REG_REQ.rd && !hit_left && !hit_right && !hit_stage
      |=> REG_RVALID && (REG_RDATA == CVO_READ_ZERO);
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved slot did not read zero");

  property p_uniform_step;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (left_gain_code >= CVO_GAIN_FLOOR)
      |=> (LEFT_GAIN.half_db == $signed({1'b0, $past(left_gain_code)}) - 9'sd207);
  endproperty
  a_uniform_step: assert property (p_uniform_step)
    else $error("gain is not linear in code");

endmodule : cvo_regs
`default_nettype wire

// ==== tb/cvo_host_model.sv ====
// host controller model that reaches the register bank over its control port
// assumes the bank takes requests on the rising edge of SYS_CLK
`timescale 1ns/1ps
`default_nettype none
module cvo_host_model
  import cvo_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic [7:0]        REG_RDATA,
  input  wire logic              REG_RVALID,
  output var  cvo_pkg::cvo_req_t REG_REQ
);
  // ********************************************************************
  // access tasks
  // ********************************************************************
  initial REG_REQ = '0;

  // idle address shows the inverse of the last value; idle data does so after a write but keeps the read's value after a read
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == CVO_OFF_RESERVED) return;
    if (addr == CVO_OFF_STAGE_CFG) begin
      d[CVO_BIT_KEEP_ONE] = 1'b1;
      if (d[3:2] == CVO_AGAIN_RSVD) d[3:2] = CVO_AGAIN_RESET;
    end
    @(negedge SYS_CLK);
    REG_REQ <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
    @(negedge SYS_CLK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~d};
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] addr, output logic valid, output logic [7:0] data);
    @(negedge SYS_CLK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~REG_REQ.wdata};
    @(negedge SYS_CLK);
    valid = REG_RVALID;
    data  = REG_RDATA;
    REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: REG_REQ.wdata};
  endtask : rd_reg
endmodule : cvo_host_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the channel gain and output stage register bank
// assumes the host model drives all requests at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cvo_pkg::*;
  logic               sys_clk;
  logic               rst_n;
  logic               speed;
  cvo_req_t           req;
  logic [7:0]         rdata;
  logic               rvalid;
  cvo_chan_t          left_gain;
  cvo_chan_t          right_gain;
  cvo_out_t           stage_out;
  int                 n_fail;
  int                 n_checks;
  int                 cycles = 0;
  logic [7:0]         codes [7] = '{8'hff, 8'hfe, 8'hcf, 8'h07, 8'h06, 8'h00, 8'h80};
  logic [4:0]         mult [8] = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
  logic [1:0]         g;
  logic [4:0]         m;

  cvo_regs dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_REQ(req), .SAMPLE_SPEED_SEL(speed),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .LEFT_GAIN(left_gain), .RIGHT_GAIN(right_gain),
    .STAGE_OUT(stage_out));
  cvo_host_model host (.SYS_CLK(sys_clk), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .REG_REQ(req));

  // ********************************************************************
  // clock, timeout and helpers
  // ********************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // the whole run needs under two hundred cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic       v;
    logic [7:0] x;
    host.rd_reg(addr, v, x);
    check({15'h0, v}, 16'h0001);
    check({8'h0, x}, {8'h0, exp});
  endtask : rd_chk

  // half decibels relative to the unity code, mute below the floor code
  function automatic logic [15:0] chan_exp(input logic [7:0] c);
    logic [8:0] h;
    h = {1'b0, c} - 9'h0cf;
    return {6'h0, (c < 8'h07), h};
  endfunction : chan_exp

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // ********************************************************************
  // tests
  // ********************************************************************
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_n = 1'b0;
    speed = 1'b0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    rd_chk(CVO_OFF_LEFT_GAIN, 8'hcf);
    rd_chk(CVO_OFF_RIGHT_GAIN, 8'hcf);
    rd_chk(CVO_OFF_STAGE_CFG, 8'h51);
    check({6'h0, left_gain}, chan_exp(8'hcf));
    check({6'h0, right_gain}, chan_exp(8'hcf));
    check({7'h0, stage_out}, {7'h0, 1'b0, 1'b0, 5'h10, 2'h0});
    $display("test reset_defaults done");
    // right channel gets the complement so both sides see distinct codes
    foreach (codes[i]) begin
      host.wr_reg(CVO_OFF_LEFT_GAIN, codes[i]);
      host.wr_reg(CVO_OFF_RIGHT_GAIN, ~codes[i]);
      @(negedge sys_clk);
      check({6'h0, left_gain}, chan_exp(codes[i]));
      check({6'h0, right_gain}, chan_exp(~codes[i]));
      rd_chk(CVO_OFF_LEFT_GAIN, codes[i]);
      rd_chk(CVO_OFF_RIGHT_GAIN, ~codes[i]);
    end
    $display("test gain_codes done");
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 8; r++) begin
        speed = s[0];
        g = r[1:0];
        host.wr_reg(CVO_OFF_STAGE_CFG, {r[0], r[2:0], g, r[1], r[2]});
        if (g == 2'h3) g = 2'h0;
        m = (s == 1) ? (mult[r] >> 1) : mult[r];
        @(negedge sys_clk);
        check({7'h0, stage_out}, {7'h0, r[0], r[1], m, g});
        rd_chk(CVO_OFF_STAGE_CFG, {r[0], r[2:0], g, r[1], 1'b1});
      end
    end
    $display("test stage_config done");
    host.wr_reg(8'h08, 8'h55);
    rd_chk(8'h08, CVO_READ_ZERO);
    rd_chk(CVO_OFF_LEFT_GAIN, 8'h80);
    rd_chk(CVO_OFF_STAGE_CFG, 8'hf3);
    $display("test unmapped_offset done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
